// File: mps_pkg.sv
// Purpose: Constants for the module power sequencer
// Assumes: 250 MHz clock, 4 ns period
// Notes: Long delays are top-level parameters, defaults below
package mps_pkg;
  localparam int unsigned CLK_PERIOD_PS = 4000;
  // Configuration phase times in seconds
  localparam int unsigned CFG_GENERIC_S = 3;
  localparam int unsigned CFG_USB_S = 5;
  localparam longint unsigned PS_PER_S = 64'd1000000000000;
  localparam longint unsigned CFG_GENERIC_CYC = CFG_GENERIC_S * PS_PER_S / CLK_PERIOD_PS;
  localparam longint unsigned CFG_USB_CYC = CFG_USB_S * PS_PER_S / CLK_PERIOD_PS;
  // Switch-on pulse window in ns, and level variant least time
  localparam int unsigned PULSE_MIN_NS = 50000;
  localparam int unsigned PULSE_MAX_NS = 80000;
  localparam int unsigned LEVEL_MIN_NS = 5000000;
  localparam int unsigned PULSE_MIN_CYC =
    (PULSE_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned PULSE_MAX_CYC = PULSE_MAX_NS * 1000 / CLK_PERIOD_PS;
  localparam int unsigned LEVEL_MIN_CYC = (LEVEL_MIN_NS / 4) * 1000 / (CLK_PERIOD_PS / 4);
  // Internal reset hold after I/O supply enable
  localparam int unsigned RST_HOLD_CYC = 1000;
  localparam int unsigned CNT_W = 32;
  typedef enum logic [2:0] {
    MPS_OFF, MPS_IO_ON, MPS_CONFIG, MPS_READY, MPS_SAVE
  } mps_state_t;
endpackage

// File: mps_sync.sv
// Purpose: Two flip-flop synchroniser for pin inputs
// Assumes: Async active-high reset
// Notes: Stage one read only by stage two
`timescale 1ns/1ps
module mps_sync #(
  parameter logic RST_VAL = 1'b0
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic din,
  output logic dout
);
  logic stage1;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      stage1 <= RST_VAL;
      dout <= RST_VAL;
    end else begin
      stage1 <= din;
      dout <= stage1;
    end
  end
endmodule // mps_sync

// File: mps_sequencer.sv
// Purpose: Power-up and power-down sequencer of a cellular module
// Assumes: Main supply good, pins and temperature flags are asynchronous
// Notes: PULSE_VARIANT selects pulse switch-on/off and reset-pin shutdown
`timescale 1ns/1ps
module mps_sequencer #(
  parameter bit PULSE_VARIANT = 1'b1,
  parameter logic [31:0] RST_HOLD_CYC = 32'(mps_pkg::RST_HOLD_CYC),
  parameter logic [31:0] CFG_GENERIC_CYC = 32'(mps_pkg::CFG_GENERIC_CYC),
  parameter logic [31:0] CFG_USB_CYC = 32'(mps_pkg::CFG_USB_CYC),
  parameter logic [31:0] PULSE_MIN_CYC = 32'(mps_pkg::PULSE_MIN_CYC),
  parameter logic [31:0] PULSE_MAX_CYC = 32'(mps_pkg::PULSE_MAX_CYC),
  parameter logic [31:0] LEVEL_MIN_CYC = 32'(mps_pkg::LEVEL_MIN_CYC)
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic main_supply_ok,
  input wire logic power_request_n,
  input wire logic ext_reset_n,
  input wire logic power_off_command,
  input wire logic temp_supervisor_command,
  input wire logic temp_danger,
  input wire logic save_done,
  output logic backup_supply_output,
  output logic io_supply_output,
  output logic reset_line_high,
  output logic internal_reset_n,
  output logic pins_oe_n,
  output logic generic_ready,
  output logic usb_ready,
  output logic save_request
);
  logic vcc_s, pwr_s, rstn_s, cmd_s, temp_en_s, temp_s, save_s;
  logic pwr_d, vcc_d;
  logic [31:0] low_cnt;
  logic [31:0] cnt;
  logic pwr_pulse_ok;
  logic abrupt;
  mps_pkg::mps_state_t state;

  mps_sync #(.RST_VAL(1'b0)) u_vcc (.clk(clk), .rst(rst), .din(main_supply_ok), .dout(vcc_s));
  mps_sync #(.RST_VAL(1'b1)) u_pwr (.clk(clk), .rst(rst), .din(power_request_n), .dout(pwr_s));
  mps_sync #(.RST_VAL(1'b1)) u_rstn (.clk(clk), .rst(rst), .din(ext_reset_n), .dout(rstn_s));
  mps_sync #(.RST_VAL(1'b0)) u_cmd (.clk(clk), .rst(rst), .din(power_off_command), .dout(cmd_s));
  mps_sync #(.RST_VAL(1'b0)) u_ten (.clk(clk), .rst(rst),
    .din(temp_supervisor_command), .dout(temp_en_s));
  mps_sync #(.RST_VAL(1'b0)) u_tmp (.clk(clk), .rst(rst), .din(temp_danger), .dout(temp_s));
  mps_sync #(.RST_VAL(1'b0)) u_sav (.clk(clk), .rst(rst), .din(save_done), .dout(save_s));

  // Low-time measurement; ignored while supply is not valid
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pwr_d <= 1'b1;
      vcc_d <= 1'b0;
      low_cnt <= 32'h0;
    end else begin
      pwr_d <= pwr_s;
      // Supply edge marks the start-up from unpowered
      vcc_d <= vcc_s;
      if (!vcc_s || pwr_s) begin
        low_cnt <= 32'h0;
      end else if (low_cnt != 32'hFFFFFFFF) begin
        low_cnt <= low_cnt + 32'h1;
      end
    end
  end

  // Valid request: pulse window on rise, or level long enough
  always_comb begin
    if (PULSE_VARIANT) begin
      pwr_pulse_ok = pwr_s && !pwr_d && vcc_s &&
        low_cnt >= PULSE_MIN_CYC && low_cnt <= PULSE_MAX_CYC;
    end else begin
      pwr_pulse_ok = !pwr_s && low_cnt == LEVEL_MIN_CYC;
    end
  end

  assign abrupt = !vcc_s || (PULSE_VARIANT && !rstn_s) ||
    (temp_en_s && temp_s);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state <= mps_pkg::MPS_OFF;
      cnt <= 32'h0;
    end else if (abrupt && state != mps_pkg::MPS_OFF) begin
      state <= mps_pkg::MPS_OFF;
      cnt <= 32'h0;
    end else begin
      case (state)
        mps_pkg::MPS_OFF: begin
          cnt <= 32'h0;
          // Supply rise from unpowered, or valid request pulse
          if (!abrupt && ((vcc_s && !vcc_d) || pwr_pulse_ok)) begin
            state <= mps_pkg::MPS_IO_ON;
          end
        end
        mps_pkg::MPS_IO_ON: begin
          if (cnt >= RST_HOLD_CYC - 32'h1) begin
            state <= mps_pkg::MPS_CONFIG;
            cnt <= 32'h0;
          end else begin
            cnt <= cnt + 32'h1;
          end
        end
        mps_pkg::MPS_CONFIG: begin
          if (cnt >= CFG_USB_CYC - 32'h1) begin
            state <= mps_pkg::MPS_READY;
          end else begin
            cnt <= cnt + 32'h1;
          end
        end
        mps_pkg::MPS_READY: begin
          if (cmd_s || (PULSE_VARIANT && pwr_pulse_ok)) begin
            state <= mps_pkg::MPS_SAVE;
          end
        end
        mps_pkg::MPS_SAVE: begin
          if (save_s) begin
            state <= mps_pkg::MPS_OFF;
          end
        end
        default: state <= mps_pkg::MPS_OFF;
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      backup_supply_output <= 1'b0;
    end else begin
      backup_supply_output <= vcc_s;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      io_supply_output <= 1'b0;
      reset_line_high <= 1'b0;
      internal_reset_n <= 1'b0;
      pins_oe_n <= 1'b1;
      generic_ready <= 1'b0;
      usb_ready <= 1'b0;
      save_request <= 1'b0;
    end else begin
      io_supply_output <= state != mps_pkg::MPS_OFF;
      reset_line_high <= state != mps_pkg::MPS_OFF;
      internal_reset_n <= state == mps_pkg::MPS_CONFIG || state == mps_pkg::MPS_READY ||
        state == mps_pkg::MPS_SAVE;
      pins_oe_n <= !(state == mps_pkg::MPS_READY || state == mps_pkg::MPS_SAVE ||
        (state == mps_pkg::MPS_CONFIG && cnt >= CFG_GENERIC_CYC));
      generic_ready <= state == mps_pkg::MPS_READY ||
        (state == mps_pkg::MPS_CONFIG && cnt >= CFG_GENERIC_CYC);
      usb_ready <= state == mps_pkg::MPS_READY;
      save_request <= state == mps_pkg::MPS_SAVE;
    end
  end

  // Sequencing checks
  chk_pins_tristate: assert property (@(posedge clk) disable iff (rst)
    !io_supply_output |-> pins_oe_n) else $error("Pins driven without I/O supply");
  chk_backup_follow: assert property (@(posedge clk) disable iff (rst)
    $rose(vcc_s) |=> backup_supply_output) else $error("Backup supply late");
  chk_backup_drop: assert property (@(posedge clk) disable iff (rst)
    !vcc_s |=> !backup_supply_output) else $error("Backup supply without main supply");
  chk_reset_hold: assert property (@(posedge clk) disable iff (rst)
    $rose(io_supply_output) |-> !internal_reset_n) else $error("Reset not held");
  chk_pins_reset: assert property (@(posedge clk) disable iff (rst)
    !internal_reset_n |-> pins_oe_n) else $error("Pins driven in reset");
  chk_reset_line: assert property (@(posedge clk) disable iff (rst)
    reset_line_high |-> io_supply_output) else $error("Reset line high early");
  chk_supply_start: assert property (@(posedge clk) disable iff (rst)
    (vcc_s && !vcc_d && state == mps_pkg::MPS_OFF && !abrupt) |=> ##1 io_supply_output)
    else $error("No start on supply rise");
  chk_pulse_start: assert property (@(posedge clk) disable iff (rst)
    (state == mps_pkg::MPS_OFF && pwr_pulse_ok && !abrupt) |=> ##1 io_supply_output)
    else $error("No start on request pulse");
  chk_abrupt_off: assert property (@(posedge clk) disable iff (rst)
    (!vcc_s && state != mps_pkg::MPS_OFF) |=> ##1 !io_supply_output)
    else $error("No abrupt shutdown");
  chk_reset_pin_off: assert property (@(posedge clk) disable iff (rst)
    (PULSE_VARIANT && !rstn_s && state != mps_pkg::MPS_OFF) |=> ##1 !io_supply_output)
    else $error("No shutdown on reset pin");
  chk_usb_after: assert property (@(posedge clk) disable iff (rst)
    usb_ready |-> internal_reset_n) else $error("USB ready in reset");
  chk_usb_order: assert property (@(posedge clk) disable iff (rst)
    usb_ready |-> generic_ready) else $error("USB ready before generic");
  chk_config_order: assert property (@(posedge clk) disable iff (rst)
    $rose(generic_ready) |-> internal_reset_n) else $error("Generic ready in reset");
  chk_save_first: assert property (@(posedge clk) disable iff (rst)
    (state == mps_pkg::MPS_READY && cmd_s && !abrupt) |=> ##1 save_request)
    else $error("No save on power off");
  chk_save_powered: assert property (@(posedge clk) disable iff (rst)
    save_request |-> io_supply_output) else $error("Save without I/O supply");
  chk_save_end: assert property (@(posedge clk) disable iff (rst)
    (state == mps_pkg::MPS_SAVE && save_s && !abrupt) |=> ##1 !io_supply_output)
    else $error("I/O supply kept after save");
  chk_pulse_off: assert property (@(posedge clk) disable iff (rst)
    (PULSE_VARIANT && state == mps_pkg::MPS_READY && pwr_pulse_ok && !abrupt)
    |=> ##1 save_request) else $error("Pulse did not start save");
  chk_temp_off: assert property (@(posedge clk) disable iff (rst)
    (temp_en_s && temp_s) |=> state == mps_pkg::MPS_OFF)
    else $error("No temperature shutdown");
endmodule // mps_sequencer

// File: mps_host.sv
// Purpose: Host model for the power sequencer
// Assumes: Pins change on the falling edge
// Notes: Answers save requests after SAVE_DLY cycles
`timescale 1ns/1ps
module mps_host #(
  parameter int SAVE_DLY = 6
) (
  input wire logic clk,
  input wire logic save_request,
  output logic power_request_n,
  output logic save_done
);
  int cnt = 0;
  initial power_request_n = 1'h1;
  initial save_done = 1'h0;
  // Low pulse of n cycles on the request pin
  task automatic pulse(input int n);
    power_request_n = 1'h0;
    repeat (n) @(negedge clk);
    power_request_n = 1'h1;
  endtask
  always @(negedge clk) begin
    cnt <= save_request ? cnt + 1 : 0;
    save_done <= save_request && cnt >= SAVE_DLY;
  end
endmodule // mps_host

// File: test_module_power_sequencer.sv
// Purpose: Self-checking bench for the power sequencer
// Assumes: Pulse variant, short counts
// Notes: Inputs change on the falling edge
`timescale 1ns/1ps
module test_module_power_sequencer;
  localparam int RH = 10, CG = 20, CU = 40;
  logic clk = 0, rst = 1, main_supply_ok = 0, ext_reset_n = 1, power_off_command = 0;
  logic temp_supervisor_command = 0, temp_danger = 0, power_request_n, save_done;
  logic backup_supply_output, io_supply_output, reset_line_high, internal_reset_n;
  logic pins_oe_n, generic_ready, usb_ready, save_request;
  int mismatches = 0, n_checks = 0;
  always #2 clk = ~clk;
  mps_sequencer #(.RST_HOLD_CYC(32'h0A), .CFG_GENERIC_CYC(32'h14), .CFG_USB_CYC(32'h28),
    .PULSE_MIN_CYC(32'h05), .PULSE_MAX_CYC(32'h14)) u_mps_sequencer (.clk, .rst,
    .main_supply_ok,
    .power_request_n, .ext_reset_n, .power_off_command, .temp_supervisor_command,
    .temp_danger, .save_done, .backup_supply_output, .io_supply_output, .reset_line_high,
    .internal_reset_n, .pins_oe_n, .generic_ready, .usb_ready, .save_request);
  mps_host u_mps_host (.clk, .save_request, .power_request_n, .save_done);
  task automatic close_out;
    if (mismatches == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input logic got, input logic exp, input string m);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %0t %s", $time, m);
    end
  endtask
  task automatic wait_cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic wio(input logic v, input int lim);
    for (int i = 0; i < lim && io_supply_output !== v; i++) @(negedge clk);
    chk(io_supply_output, v, "io supply");
  endtask
  task automatic t_ramp;
    u_mps_host.pulse(10);
    wait_cyc(8);
    chk(io_supply_output, 1'h0, "io on unpowered");
    chk(backup_supply_output, 1'h0, "backup early");
    chk(pins_oe_n, 1'h1, "pins driven");
    main_supply_ok = 1'h1;
    wait_cyc(3);
    chk(backup_supply_output, 1'h1, "backup late");
    chk(io_supply_output, 1'h0, "io before backup");
    t_seq();
  endtask
  task automatic t_on;
    u_mps_host.pulse(10);
    t_seq();
  endtask
  task automatic t_seq;
    wio(1'h1, 8);
    chk(reset_line_high, 1'h1, "reset line low");
    chk(pins_oe_n, 1'h1, "pins early");
    wait_cyc(RH - 3);
    chk(internal_reset_n, 1'h0, "reset short");
    wait_cyc(5);
    chk(internal_reset_n, 1'h1, "reset stuck");
    wait_cyc(CG - 5);
    chk(generic_ready, 1'h0, "generic early");
    wait_cyc(5);
    chk(generic_ready, 1'h1, "generic late");
    chk(pins_oe_n, 1'h0, "pins idle");
    wait_cyc(CU - CG - 5);
    chk(usb_ready, 1'h0, "usb early");
    wait_cyc(5);
    chk(usb_ready, 1'h1, "usb late");
  endtask
  task automatic t_cmd_off;
    power_off_command = 1'h1;
    wait_cyc(6);
    chk(save_request, 1'h1, "no save");
    chk(io_supply_output, 1'h1, "io dropped early");
    power_off_command = 1'h0;
    wio(1'h0, 20);
    chk(backup_supply_output, 1'h1, "backup off");
  endtask
  task automatic t_short;
    int w[2] = '{2, 25};
    foreach (w[k]) begin
      u_mps_host.pulse(w[k]);
      wait_cyc(8);
      chk(io_supply_output, 1'h0, "bad pulse taken");
    end
  endtask
  task automatic t_pulse_off;
    u_mps_host.pulse(10);
    wait_cyc(5);
    chk(save_request, 1'h1, "pulse no save");
    wio(1'h0, 20);
  endtask
  task automatic t_abrupt(input int s);
    case (s)
      0: ext_reset_n = 1'h0;
      1: begin
        temp_danger = 1'h1;
        wait_cyc(8);
        chk(io_supply_output, 1'h1, "temp off disabled");
        temp_supervisor_command = 1'h1;
      end
      default: main_supply_ok = 1'h0;
    endcase
    wait_cyc(2);
    chk(save_request, 1'h0, "save on abrupt");
    wait_cyc(4);
    chk(io_supply_output, 1'h0, "no abrupt off");
    chk(backup_supply_output, main_supply_ok, "backup");
    ext_reset_n = 1'h1;
    temp_danger = 1'h0;
    temp_supervisor_command = 1'h0;
    wait_cyc(6);
  endtask
  initial begin
    #20000;
    mismatches++;
    close_out();
  end
  initial begin
    wait_cyc(2);
    rst = 1'h0;
    t_ramp();
    t_cmd_off();
    t_short();
    t_on();
    t_pulse_off();
    for (int s = 0; s < 3; s++) begin
      t_on();
      t_abrupt(s);
    end
    close_out();
  end
endmodule // test_module_power_sequencer
